// ===== include/rtc_regs.vh
/*
  register offsets, bit positions, reset values and timing constants
  for the reload timer with clock output.
  assumes inclusion by bare name from the design file.
*/
// What this block does
// - count is a 16-bit pair, low byte carrying into high byte.
// - outside baud and clock-out modes, source select clear counts oscillator over 12, set counts external pin.
// - counter operation advances on each falling edge of the external pin, except in baud or clock-out mode.
// - low byte advances only while run bit set; clearing it stops the timer.
// - receive clock, transmit clock and capture/reload bits pick the mode.
// - with trigger enabled, trigger falling edge captures or reloads, sets external flag.
// - auto-reload with down-count enable set acts as up/down counter.
// - in up/down mode trigger pin high counts up, low counts down.
// - counting up past ffff is overflow; sets overflow flag, raises interrupt request.
// - up-count overflow copies the reload pair into the count; in capture mode it loads 0000.
// - down count equal to reload pair underflows: set flag, load ffff.
// - in up/down mode external flag toggles on wrap, no interrupt.
// - overflow flag set only when both baud selects are zero; software clears.
// - each baud select picks timer 1 overflow or this timer's overflow.
// - clock-out mode counts at oscillator over 2, drives 50% clock on pin.
// - in clock-out mode overflow reloads from reload pair, no interrupt.
// - clock-out frequency is oscillator over 4 times (65536 minus reload).
// - baud generation and clock output may run together on shared reload pair.
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RTC_ADDR_CONTROL 8'hc8
`define RTC_ADDR_MODE 8'hc9
`define RTC_ADDR_RELOAD_LOW 8'hca
`define RTC_ADDR_RELOAD_HIGH 8'hcb
`define RTC_ADDR_COUNT_LOW 8'hcc
`define RTC_ADDR_COUNT_HIGH 8'hcd

// ----------------------------------------
// control register bits
// ----------------------------------------
`define RTC_CTL_OVF 7
`define RTC_CTL_EXT 6
`define RTC_CTL_RCLK 5
`define RTC_CTL_TRANSMIT_BAUD_SELECT 4
`define RTC_CTL_TRIG_EN 3
`define RTC_CTL_RUN 2
`define RTC_CTL_SRC 1
`define RTC_CTL_CAPSEL 0

// ----------------------------------------
// mode register bits
// ----------------------------------------
`define RTC_MODE_CKOE 1
`define RTC_MODE_DOWN_COUNT_ENABLE 0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RTC_RESET_BYTE 8'h00
`define RTC_RESET_WORD 16'h0000
`define RTC_WORD_FULL 16'hffff
`define RTC_OSC_DIV 12
`define RTC_PRESCALE_LAST 4'hb
`define RTC_PRESCALE_ZERO 4'h0

`endif

// ===== design/rtc_timer.v
/*
  16-bit reload timer with capture, up/down auto-reload, baud clock
  and programmable clock output.
  assumes one clock at the oscillator rate, synchronous pins and a
  simple strobe register port with read data one cycle late.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.vh"

module rtc_timer (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire external_count_pin_in,
  output reg external_count_pin_out,
  output reg external_count_pin_oe_b_out,
  input wire trigger_direction_pin_in,
  input wire timer1_overflow_in,
  output reg rx_baud_tick_out,
  output reg tx_baud_tick_out,
  output reg irq_out
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg overflow_flag;
  reg external_flag;
  reg rclk_sel;
  reg transmit_baud_select;
  reg external_trigger_enable;
  reg run_control;
  reg count_source_select;
  reg capture_reload_select;
  reg clock_output_enable;
  reg down_count_enable;
  reg [7:0] reload_low_byte;
  reg [7:0] reload_high_byte;
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [3:0] prescale;
  reg half_phase;
  reg ext_prev;
  reg trig_prev;
  reg clk_level;

  reg [15:0] next_count;
  reg next_ovf_evt;
  reg next_unf_evt;
  reg tick;

  wire [15:0] count_word;
  wire [15:0] reload_word;
  wire baud_mode;
  wire updown_mode;
  wire ext_fall;
  wire trig_fall;
  wire wr_ctl;

  assign count_word = {count_high_byte, count_low_byte};
  assign reload_word = {reload_high_byte, reload_low_byte};
  assign baud_mode = rclk_sel | transmit_baud_select;
  assign updown_mode = down_count_enable & ~baud_mode & ~capture_reload_select;
  assign ext_fall = ext_prev & ~external_count_pin_in;
  assign trig_fall = trig_prev & ~trigger_direction_pin_in & external_trigger_enable;
  assign wr_ctl = reg_wr_in & (reg_addr_in == `RTC_ADDR_CONTROL);

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = reg_wr_in & (a == b);
    end
  endfunction

  // ----------------------------------------
  // count input select
  // ----------------------------------------
  always @* begin
    tick = 1'b0;
    if (run_control) begin
      if (clock_output_enable | baud_mode) begin
        tick = half_phase;
      end else if (count_source_select) begin
        tick = ext_fall;
      end else begin
        tick = (prescale == `RTC_PRESCALE_LAST);
      end
    end
  end

  // ----------------------------------------
  // next count
  // ----------------------------------------
  always @* begin
    next_count = count_word;
    next_ovf_evt = 1'b0;
    next_unf_evt = 1'b0;
    if (tick) begin
      if (updown_mode & ~trigger_direction_pin_in) begin
        if (count_word == reload_word) begin
          next_unf_evt = 1'b1;
          next_count = `RTC_WORD_FULL;
        end else begin
          next_count = count_word - 16'h0001;
        end
      end else if (count_word == `RTC_WORD_FULL) begin
        next_ovf_evt = 1'b1;
        if (capture_reload_select & ~baud_mode & ~clock_output_enable) begin
          next_count = `RTC_RESET_WORD;
        end else begin
          next_count = reload_word;
        end
      end else begin
        next_count = count_word + 16'h0001;
      end
    end
    if (trig_fall & ~capture_reload_select & ~baud_mode & ~down_count_enable) begin
      next_count = reload_word;
    end
  end

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
      rclk_sel <= 1'b0;
      transmit_baud_select <= 1'b0;
      external_trigger_enable <= 1'b0;
      run_control <= 1'b0;
      count_source_select <= 1'b0;
      capture_reload_select <= 1'b0;
      clock_output_enable <= 1'b0;
      down_count_enable <= 1'b0;
      reload_low_byte <= `RTC_RESET_BYTE;
      reload_high_byte <= `RTC_RESET_BYTE;
      count_low_byte <= `RTC_RESET_BYTE;
      count_high_byte <= `RTC_RESET_BYTE;
      prescale <= `RTC_PRESCALE_ZERO;
      half_phase <= 1'b0;
      ext_prev <= 1'b1;
      trig_prev <= 1'b1;
      clk_level <= 1'b0;
      reg_rdata_out <= `RTC_RESET_BYTE;
      external_count_pin_out <= 1'b0;
      external_count_pin_oe_b_out <= 1'b1;
      rx_baud_tick_out <= 1'b0;
      tx_baud_tick_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      ext_prev <= external_count_pin_in;
      trig_prev <= trigger_direction_pin_in;
      half_phase <= ~half_phase;
      prescale <= (prescale == `RTC_PRESCALE_LAST) ? `RTC_PRESCALE_ZERO : prescale + 4'h1;

      // software writes first; hardware flag and capture events below take priority
      if (wr_ctl) begin
        overflow_flag <= reg_wdata_in[`RTC_CTL_OVF];
        external_flag <= reg_wdata_in[`RTC_CTL_EXT];
        rclk_sel <= reg_wdata_in[`RTC_CTL_RCLK];
        transmit_baud_select <= reg_wdata_in[`RTC_CTL_TRANSMIT_BAUD_SELECT];
        external_trigger_enable <= reg_wdata_in[`RTC_CTL_TRIG_EN];
        run_control <= reg_wdata_in[`RTC_CTL_RUN];
        count_source_select <= reg_wdata_in[`RTC_CTL_SRC];
        capture_reload_select <= reg_wdata_in[`RTC_CTL_CAPSEL];
      end
      if (hit(reg_addr_in, `RTC_ADDR_MODE)) begin
        clock_output_enable <= reg_wdata_in[`RTC_MODE_CKOE];
        down_count_enable <= reg_wdata_in[`RTC_MODE_DOWN_COUNT_ENABLE];
      end
      if (hit(reg_addr_in, `RTC_ADDR_RELOAD_LOW)) begin
        reload_low_byte <= reg_wdata_in;
      end
      if (hit(reg_addr_in, `RTC_ADDR_RELOAD_HIGH)) begin
        reload_high_byte <= reg_wdata_in;
      end

      // count write by software overrides the counting step
      count_low_byte <= hit(reg_addr_in, `RTC_ADDR_COUNT_LOW) ? reg_wdata_in : next_count[7:0];
      count_high_byte <= hit(reg_addr_in, `RTC_ADDR_COUNT_HIGH) ? reg_wdata_in : next_count[15:8];

      if (trig_fall & capture_reload_select & ~baud_mode) begin
        reload_low_byte <= count_low_byte;
        reload_high_byte <= count_high_byte;
      end
      // external flag set, not in up/down mode
      if (trig_fall & ~updown_mode) begin
        external_flag <= 1'b1;
      end
      if (updown_mode & (next_ovf_evt | next_unf_evt)) begin
        external_flag <= ~(wr_ctl ? reg_wdata_in[`RTC_CTL_EXT] : external_flag);
      end
      // flag only outside baud mode, not in clock-out
      if ((next_ovf_evt | next_unf_evt) & ~baud_mode & ~clock_output_enable) begin
        overflow_flag <= 1'b1;
      end

      // toggle pin on each overflow for 50% duty
      if (clock_output_enable & next_ovf_evt) begin
        clk_level <= ~clk_level;
      end
      external_count_pin_out <= clk_level;
      // pin drives only once output enable and timer source chosen
      external_count_pin_oe_b_out <= ~(clock_output_enable & ~count_source_select);

      rx_baud_tick_out <= rclk_sel ? (next_ovf_evt & baud_mode) : timer1_overflow_in;
      tx_baud_tick_out <= transmit_baud_select ? (next_ovf_evt & baud_mode) : timer1_overflow_in;
      // interrupt request, external flag only while down-count enable clear
      irq_out <= overflow_flag | (external_flag & ~down_count_enable);

      reg_rdata_out <= `RTC_RESET_BYTE;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `RTC_ADDR_CONTROL: begin
            reg_rdata_out <= {overflow_flag, external_flag, rclk_sel, transmit_baud_select,
              external_trigger_enable, run_control, count_source_select, capture_reload_select};
          end
          `RTC_ADDR_MODE: begin
            reg_rdata_out <= {6'h00, clock_output_enable, down_count_enable};
          end
          `RTC_ADDR_RELOAD_LOW: begin
            reg_rdata_out <= reload_low_byte;
          end
          `RTC_ADDR_RELOAD_HIGH: begin
            reg_rdata_out <= reload_high_byte;
          end
          `RTC_ADDR_COUNT_LOW: begin
            reg_rdata_out <= count_low_byte;
          end
          `RTC_ADDR_COUNT_HIGH: begin
            reg_rdata_out <= count_high_byte;
          end
          default: begin
            reg_rdata_out <= `RTC_RESET_BYTE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/rtc_pin_model.sv
/* far side of the count pin: pulse source, pull-up, clock-out meter.
   assumes one clock shared with the timer. */
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_model (
  input wire logic clk_in,
  input wire logic oe_b_in,
  input wire logic drv_in,
  output logic pin_out,
  output int half_out
);
  logic lvl = 1'b1;
  logic prev = 1'b0;
  int cnt = 0;
  assign pin_out = oe_b_in ? lvl : drv_in;
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      lvl <= 1'b0;
      repeat (3) @(posedge clk_in);
      lvl <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
  endtask
  always @(posedge clk_in) begin
    prev <= drv_in;
    cnt <= (prev != drv_in) ? 1 : cnt + 1;
    if (prev != drv_in) half_out <= cnt;
  end
endmodule
`default_nettype wire

// ===== tb/rtc_timer_sva.sv
/* port checker for the reload timer.
   assumes register writes are the only way software bits change. */
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_sva (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic external_count_pin_out,
  input wire logic external_count_pin_oe_b_out,
  input wire logic timer1_overflow_in,
  input wire logic rx_baud_tick_out,
  input wire logic tx_baud_tick_out,
  input wire logic irq_out
);
  // ----------------------------------------
  // software bit shadows
  // ----------------------------------------
  logic [7:0] ctl;
  logic [7:0] mode;
  logic ck2;
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ctl <= 8'h00;
      mode <= 8'h00;
      ck2 <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'hc8) ctl <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'hc9) mode <= reg_wdata_in;
      ck2 <= mode[1];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_mode_wr;
    reg_wr_in && reg_addr_in == 8'hc9;
  endsequence
  sequence s_ck_idle;
    (mode[1] && !ctl[2]) [*3];
  endsequence
  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rst_vals; $rose(rst_b_in) |-> external_count_pin_oe_b_out && !irq_out; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
  // pin drive follows output enable and timer source, one cycle late
  property p_oe_on; s_mode_wr ##1 (mode[1] && !ctl[1]) |=> !external_count_pin_oe_b_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_oe_off; !(mode[1] && !ctl[1]) |=> external_count_pin_oe_b_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin not released");
  property p_rx_t1; !ctl[5] && timer1_overflow_in |=> rx_baud_tick_out; endproperty
  a_rx_t1: assert property (p_rx_t1) else $error("rx tick missing");
  property p_tx_t1; !ctl[4] && timer1_overflow_in |=> tx_baud_tick_out; endproperty
  a_tx_t1: assert property (p_tx_t1) else $error("tx tick missing");
  property p_rx_quiet; (ctl[5] && !ctl[2]) [*2] |=> !rx_baud_tick_out; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("tick while stopped");
  property p_clk_stop; s_ck_idle |=> $stable(external_count_pin_out); endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock out while stopped");
  property p_no_irq; ck2 && mode[1] && !ctl[3] && !irq_out && !reg_wr_in |=> !irq_out; endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq in clock-out");
endmodule
bind rtc_timer rtc_timer_sva chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .external_count_pin_out(external_count_pin_out),
  .external_count_pin_oe_b_out(external_count_pin_oe_b_out), .timer1_overflow_in(timer1_overflow_in),
  .rx_baud_tick_out(rx_baud_tick_out), .tx_baud_tick_out(tx_baud_tick_out), .irq_out(irq_out));
`default_nettype wire

// ===== tb/tb.sv
/* self-checking bench for the reload timer.
   assumes pin model and checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, trig = 1'b1, t1 = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic pin, pin_o, oe_b, rxt, txt, irq;
  int half, errors = 0, n_checks = 0, cyc = 0;
  rtc_timer dut (.core_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .external_count_pin_in(pin),
    .external_count_pin_out(pin_o), .external_count_pin_oe_b_out(oe_b),
    .trigger_direction_pin_in(trig), .timer1_overflow_in(t1), .rx_baud_tick_out(rxt),
    .tx_baud_tick_out(txt), .irq_out(irq));
  rtc_pin_model pm (.clk_in(clk), .oe_b_in(oe_b), .drv_in(pin_o), .pin_out(pin), .half_out(half));
  always #4 clk = ~clk;
  // ----------------------------------------
  // timer 1 stand-in and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    t1 <= (cyc % 50 == 0);
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wr_word(input logic [7:0] a, input logic [15:0] w);
    wr_reg(a, w[7:0]);
    wr_reg(a + 8'h01, w[15:8]);
  endtask
  task automatic chk_word(input string nm, input logic [7:0] a, input logic [15:0] exp);
    logic [7:0] lo, hi;
    rd_reg(a, lo);
    rd_reg(a + 8'h01, hi);
    chk(nm, {hi, lo}, exp);
  endtask
  task automatic t_regs;
    logic [7:0] v;
    for (int a = 200; a <= 205; a++) begin
      rd_reg(a[7:0], v);
      chk("reset reg", {8'h00, v}, 16'h0000);
    end
    wr_reg(8'hd0, 8'h5a);
    rd_reg(8'hd0, v);
    chk("unmapped", {8'h00, v}, 16'h0000);
    wr_word(8'hca, 16'h1234);
    chk_word("reload pair", 8'hca, 16'h1234);
    $display("t_regs done");
  endtask
  task automatic t_timer;
    logic [7:0] v, w;
    wr_reg(8'hc8, 8'h04);
    repeat (118) @(posedge clk);
    wr_reg(8'hc8, 8'h00);
    rd_reg(8'hcc, v);
    chk("osc over 12", {15'h0000, v >= 8'h09 && v <= 8'h0b}, 16'h0001);
    repeat (40) @(posedge clk);
    rd_reg(8'hcc, w);
    chk("stopped count", {8'h00, w}, {8'h00, v});
    $display("t_timer done");
  endtask
  task automatic t_updown;
    logic [7:0] v;
    wr_reg(8'hc9, 8'h01);
    wr_word(8'hcc, 16'hfffe);
    wr_reg(8'hc8, 8'h06);
    pm.pulse(2);
    chk_word("up wrap", 8'hcc, 16'h1234);
    rd_reg(8'hc8, v);
    chk("up flags", {8'h00, v}, 16'h00c6);
    chk("up irq", {15'h0000, irq}, 16'h0001);
    wr_reg(8'hc8, 8'h46);
    trig <= 1'b0;
    wr_word(8'hcc, 16'h1235);
    chk("ext no irq", {15'h0000, irq}, 16'h0000);
    pm.pulse(2);
    chk_word("down wrap", 8'hcc, 16'hffff);
    rd_reg(8'hc8, v);
    chk("down flags", {8'h00, v}, 16'h0086);
    $display("t_updown done");
  endtask
  task automatic t_trigger;
    logic [7:0] v;
    wr_reg(8'hc9, 8'h00);
    trig <= 1'b1;
    wr_word(8'hcc, 16'h0042);
    wr_reg(8'hc8, 8'h0f);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    chk_word("capture", 8'hca, 16'h0042);
    rd_reg(8'hc8, v);
    chk("ext flag", {7'h00, irq, v}, 16'h014f);
    trig <= 1'b1;
    wr_word(8'hcc, 16'h0000);
    wr_reg(8'hc8, 8'h0e);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    chk_word("trig reload", 8'hcc, 16'h0042);
    $display("t_trigger done");
  endtask
  task automatic t_clkout;
    logic [7:0] v;
    int n;
    wr_reg(8'hc9, 8'h02);
    wr_reg(8'hc8, 8'h00);
    wr_word(8'hca, 16'hfffc);
    wr_word(8'hcc, 16'hfffc);
    wr_reg(8'hc8, 8'h24);
    repeat (60) @(posedge clk);
    chk("pin driven", {15'h0000, oe_b}, 16'h0000);
    chk("half period", half[15:0], 16'h0008);
    n = 0;
    repeat (80) begin
      @(posedge clk);
      #1 if (rxt === 1'b1) n++;
    end
    chk("rx ticks", n[15:0], 16'h000a);
    wr_reg(8'hc8, 8'h20);
    repeat (10) @(posedge clk);
    rd_reg(8'hc8, v);
    chk("no flag", {7'h00, irq, v}, 16'h0020);
    $display("t_clkout done");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_timer();
    t_updown();
    t_trigger();
    t_clkout();
    close_out();
  end
endmodule
`default_nettype wire
